// ==== design/psl_top.sv ====
/*
 * Strap latch and shared MII receive pins with an AXI4-Lite register
 * slave and open-drain management data pin.
 * Assumes board pull resistors on the shared pins, a 125 MHz aclk and a
 * management controller clocking MDC far slower than aclk.
 */
`include "psl_consts.svh"

// Contract
// - RXD3..RXD1 latch as address bits 0..2
// - RXD0 latches as initial duplex
// - RX_DV latches as interface select bit
// - RX_CLK latches as broadcast address disable
// - RX_ER latches as initial mac_port_detach_strap setting
// - Run mode drives nibble, valid, clock, error
// - MDIO only pulled low or released
// - Logic runs from the reference clock
module psl_top (
    input  wire logic                aclk,          // System clock
    input  wire logic                aresetn,       // Sync reset, low
    input  wire logic [7:0]          s_axi_awaddr,  // Write address
    input  wire logic                s_axi_awvalid, // Write addr valid
    output      logic                s_axi_awready, // Write addr ready
    input  wire logic [31:0]         s_axi_wdata,   // Write data
    input  wire logic [3:0]          s_axi_wstrb,   // Write strobes
    input  wire logic                s_axi_wvalid,  // Write data valid
    output      logic                s_axi_wready,  // Write data ready
    output      logic [1:0]          s_axi_bresp,   // Write response
    output      logic                s_axi_bvalid,  // Write resp valid
    input  wire logic                s_axi_bready,  // Write resp ready
    input  wire logic [7:0]          s_axi_araddr,  // Read address
    input  wire logic                s_axi_arvalid, // Read addr valid
    output      logic                s_axi_arready, // Read addr ready
    output      logic [31:0]         s_axi_rdata,   // Read data
    output      logic [1:0]          s_axi_rresp,   // Read response
    output      logic                s_axi_rvalid,  // Read data valid
    input  wire logic                s_axi_rready,  // Read data ready
    input  wire psl_pkg::psl_rx_t    rx_data,       // Core receive data
    input  wire logic [3:0]          rxd_i,         // Nibble pin level
    output      logic [3:0]          rxd_o,         // Nibble pin drive
    output      logic                rxd_oe,        // Nibble pin enable
    input  wire logic                rx_dv_i,       // Valid pin level
    output      logic                rx_dv_o,       // Valid pin drive
    output      logic                rx_dv_oe,      // Valid pin enable
    input  wire logic                rx_clk_i,      // Clock pin level
    output      logic                rx_clk_o,      // Clock pin drive
    output      logic                rx_clk_oe,     // Clock pin enable
    input  wire logic                rx_er_i,       // Error pin level
    output      logic                rx_er_o,       // Error pin drive
    output      logic                rx_er_oe,      // Error pin enable
    input  wire logic                mdc_i,         // Management clock
    input  wire logic                mdio_i,        // MDIO pin level
    output      logic                mdio_o,        // MDIO drive, low
    output      logic                mdio_oe,       // MDIO pull enable
    input  wire logic                mgmt_drive_en, // Core owns MDIO
    input  wire logic                mgmt_drive_bit,// Core MDIO bit
    output      logic                mgmt_sample,   // MDIO at MDC rise
    output      logic                mgmt_mdc_rise, // MDC rise pulse
    output      psl_pkg::psl_strap_t strap_cfg,     // Captured straps
    output      logic                duplex_mode,   // Active duplex
    output      logic                detach_active  // Pins detached
);
    import psl_pkg::*;

    // ============================================================
    // Pin synchronisers
    psl_pins_t pins_async;
    psl_pins_t pins_sync;

    assign pins_async = '{mdio: mdio_i, mdc: mdc_i, rx_er: rx_er_i,
                          rx_clk: rx_clk_i, rx_dv: rx_dv_i, rxd: rxd_i};

    psl_sync2 #(
        .W ($bits(psl_pins_t))
    ) u_sync (
        .aclk (aclk),
        .din  (pins_async),
        .dout (pins_sync)
    );

    // ============================================================
    // Strap capture and run state
    psl_state_t state_ff,  nxt_state_ff;
    psl_strap_t strap_ff,  nxt_strap_ff;
    logic [1:0] ctrl_ff,   nxt_ctrl_ff;
    logic       wr_do;
    logic [1:0] wr_ctrl;

    // Capture in the first cycle after release; pins are still undriven
    always_comb begin
        nxt_state_ff = state_ff;
        nxt_strap_ff = strap_ff;
        nxt_ctrl_ff  = ctrl_ff;
        case (state_ff)
            st_capture: begin
                nxt_strap_ff.station_address_strap =
                    {pins_sync.rxd[1], pins_sync.rxd[2],
                     pins_sync.rxd[3]};
                nxt_strap_ff.duplex_strap = pins_sync.rxd[0];
                nxt_strap_ff.interface_select_strap_msb =
                    pins_sync.rx_dv;
                nxt_strap_ff.broadcast_addr_disable_strap =
                    pins_sync.rx_clk;
                nxt_strap_ff.mac_port_detach_strap =
                    pins_sync.rx_er;
                nxt_ctrl_ff[`PSL_CTRL_DETACH_BIT] = pins_sync.rx_er;
                nxt_ctrl_ff[`PSL_CTRL_DUPLEX_BIT] = pins_sync.rxd[0];
                nxt_state_ff = st_run;
            end
            st_run: begin
                if (wr_do) begin
                    nxt_ctrl_ff = wr_ctrl;
                end
            end
            default: begin
                nxt_state_ff = st_capture;
            end
        endcase
    end

    // Straps change only in the capture state, so they hold until reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= st_capture;
            strap_ff <= `PSL_STRAP_RST;
            ctrl_ff  <= `PSL_CTRL_RST;
        end else begin
            state_ff <= nxt_state_ff;
            strap_ff <= nxt_strap_ff;
            ctrl_ff  <= nxt_ctrl_ff;
        end
    end

    // ============================================================
    // AXI4-Lite write channel
    logic aw_held_ff, nxt_aw_held_ff;
    logic w_held_ff,  nxt_w_held_ff;
    logic awready_ff, nxt_awready_ff;
    logic wready_ff,  nxt_wready_ff;
    logic bvalid_ff,  nxt_bvalid_ff;
    logic [1:0] bresp_ff, nxt_bresp_ff;
    logic [7:0] awaddr_ff, nxt_awaddr_ff;
    logic [31:0] wdata_ff, nxt_wdata_ff;
    logic [3:0] wstrb_ff, nxt_wstrb_ff;

    // Address and data may arrive in either order; each is held alone
    always_comb begin
        nxt_aw_held_ff = aw_held_ff;
        nxt_w_held_ff  = w_held_ff;
        nxt_awaddr_ff  = awaddr_ff;
        nxt_wdata_ff   = wdata_ff;
        nxt_wstrb_ff   = wstrb_ff;
        nxt_bvalid_ff  = bvalid_ff;
        nxt_bresp_ff   = bresp_ff;
        wr_do          = 1'b0;
        wr_ctrl        = ctrl_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_held_ff = 1'b1;
            nxt_awaddr_ff  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_held_ff = 1'b1;
            nxt_wdata_ff  = s_axi_wdata;
            nxt_wstrb_ff  = s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid_ff = 1'b0;
        end
        if (aw_held_ff && w_held_ff && !bvalid_ff) begin
            nxt_aw_held_ff = 1'b0;
            nxt_w_held_ff  = 1'b0;
            nxt_bvalid_ff  = 1'b1;
            nxt_bresp_ff   = `PSL_RESP_OKAY;
            case (awaddr_ff)
                `PSL_CTRL_OFS: begin
                    wr_do = wstrb_ff[0];
                    wr_ctrl = wdata_ff[1:0];
                end
                `PSL_STRAP_OFS, `PSL_STAT_OFS: begin
                    wr_do = 1'b0;
                end
                default: begin
                    nxt_bresp_ff = `PSL_RESP_SLVERR;
                end
            endcase
        end
        nxt_awready_ff = !nxt_aw_held_ff && !nxt_bvalid_ff;
        nxt_wready_ff  = !nxt_w_held_ff && !nxt_bvalid_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `PSL_RESP_OKAY;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            aw_held_ff <= nxt_aw_held_ff;
            w_held_ff  <= nxt_w_held_ff;
            awready_ff <= nxt_awready_ff;
            wready_ff  <= nxt_wready_ff;
            bvalid_ff  <= nxt_bvalid_ff;
            bresp_ff   <= nxt_bresp_ff;
            awaddr_ff  <= nxt_awaddr_ff;
            wdata_ff   <= nxt_wdata_ff;
            wstrb_ff   <= nxt_wstrb_ff;
        end
    end

    // ============================================================
    // AXI4-Lite read channel
    logic        arready_ff, nxt_arready_ff;
    logic        rvalid_ff,  nxt_rvalid_ff;
    logic [31:0] rdata_ff,   nxt_rdata_ff;
    logic [1:0]  rresp_ff,   nxt_rresp_ff;
    logic        drive_ff,   nxt_drive_ff;

    // One read in flight; unmapped addresses answer zero with an error
    always_comb begin
        nxt_rvalid_ff = rvalid_ff;
        nxt_rdata_ff  = rdata_ff;
        nxt_rresp_ff  = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid_ff = 1'b0;
        end
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid_ff = 1'b1;
            nxt_rresp_ff  = `PSL_RESP_OKAY;
            nxt_rdata_ff  = 32'h0000_0000;
            case (s_axi_araddr)
                `PSL_STRAP_OFS: nxt_rdata_ff[$bits(psl_strap_t)-1:0] =
                    strap_ff;
                `PSL_CTRL_OFS: nxt_rdata_ff[1:0] = ctrl_ff;
                `PSL_STAT_OFS: begin
                    nxt_rdata_ff[`PSL_STAT_CAPT_BIT] = (state_ff == st_run);
                    nxt_rdata_ff[`PSL_STAT_DRIVE_BIT] = drive_ff;
                end
                default: nxt_rresp_ff = `PSL_RESP_SLVERR;
            endcase
        end
        nxt_arready_ff = !nxt_rvalid_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `PSL_RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready_ff;
            rvalid_ff  <= nxt_rvalid_ff;
            rdata_ff   <= nxt_rdata_ff;
            rresp_ff   <= nxt_rresp_ff;
        end
    end

    // ============================================================
    // Receive pin drive and receive clock divider
    localparam logic [2:0] RXCLK_LAST = 3'(`PSL_RXCLK_DIV - 1);
    localparam logic [2:0] RXCLK_HIGH = 3'(`PSL_RXCLK_HIGH);
    logic [2:0] div_ff,   nxt_div_ff;
    psl_rx_t    rxo_ff,   nxt_rxo_ff;
    logic       rxclk_ff, nxt_rxclk_ff;

    // Divider derives the receive clock from the reference clock
    always_comb begin
        nxt_div_ff   = (div_ff == RXCLK_LAST) ? 3'h0 : div_ff + 3'h1;
        nxt_rxclk_ff = (nxt_div_ff < RXCLK_HIGH);
        nxt_rxo_ff   = rx_data;
        // Drivers wait for capture and stay off while detached
        nxt_drive_ff = (state_ff == st_run) &&
                       !nxt_ctrl_ff[`PSL_CTRL_DETACH_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff   <= RXCLK_LAST;  // First high phase is full length
            rxclk_ff <= 1'b0;
            rxo_ff   <= '0;
            drive_ff <= 1'b0;
        end else begin
            div_ff   <= nxt_div_ff;
            rxclk_ff <= nxt_rxclk_ff;
            rxo_ff   <= nxt_rxo_ff;
            drive_ff <= nxt_drive_ff;
        end
    end

    // ============================================================
    // Management data pin, open drain
    logic mdc_d_ff,   nxt_mdc_d_ff;
    logic rise_ff,    nxt_rise_ff;
    logic sample_ff,  nxt_sample_ff;
    logic mdoe_ff,    nxt_mdoe_ff;

    // MDC is slow, so a sampled edge is early enough to move MDIO
    always_comb begin
        nxt_mdc_d_ff  = pins_sync.mdc;
        nxt_rise_ff   = pins_sync.mdc && !mdc_d_ff;
        nxt_sample_ff = sample_ff;
        nxt_mdoe_ff   = mdoe_ff;
        if (nxt_rise_ff) begin
            nxt_sample_ff = pins_sync.mdio;
            nxt_mdoe_ff   = mgmt_drive_en && !mgmt_drive_bit;
        end
        if (!mgmt_drive_en) begin
            nxt_mdoe_ff = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mdc_d_ff  <= 1'b0;
            rise_ff   <= 1'b0;
            sample_ff <= 1'b0;
            mdoe_ff   <= 1'b0;
        end else begin
            mdc_d_ff  <= nxt_mdc_d_ff;
            rise_ff   <= nxt_rise_ff;
            sample_ff <= nxt_sample_ff;
            mdoe_ff   <= nxt_mdoe_ff;
        end
    end

    // ============================================================
    // Output wiring, all from flip-flops except mdio_o, tied to a constant 0
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign rxd_o         = rxo_ff.rxd;
    assign rx_dv_o       = rxo_ff.rx_dv;
    assign rx_er_o       = rxo_ff.rx_er;
    assign rx_clk_o      = rxclk_ff;
    assign rxd_oe        = drive_ff;
    assign rx_dv_oe      = drive_ff;
    assign rx_clk_oe     = drive_ff;
    assign rx_er_oe      = drive_ff;
    assign mdio_o        = 1'b0;        // Never drives high
    assign mdio_oe       = mdoe_ff;
    assign mgmt_sample   = sample_ff;
    assign mgmt_mdc_rise = rise_ff;
    assign strap_cfg     = strap_ff;
    assign duplex_mode   = ctrl_ff[`PSL_CTRL_DUPLEX_BIT];
    assign detach_active = ctrl_ff[`PSL_CTRL_DETACH_BIT];

endmodule // psl_top

// ==== design/psl_consts.svh ====
/*
 * Offsets, field positions, reset values and timing counts for the strap
 * latch and MII receive pin block.
 * Assumes inclusion by bare name wherever these constants are needed.
 */
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH

// ============================================================
// Register offsets (byte addresses, one aligned word each)
`define PSL_STRAP_OFS       8'h00
`define PSL_CTRL_OFS        8'h04
`define PSL_STAT_OFS        8'h08

// ============================================================
// Field positions
`define PSL_CTRL_DETACH_BIT 0
`define PSL_CTRL_DUPLEX_BIT 1
`define PSL_STAT_CAPT_BIT   0
`define PSL_STAT_DRIVE_BIT  1

// ============================================================
// Reset values
`define PSL_CTRL_RST        2'h0
`define PSL_STRAP_RST       7'h00

// ============================================================
// Bus response codes
`define PSL_RESP_OKAY       2'h0
`define PSL_RESP_SLVERR     2'h2

// ============================================================
// Timing: system clock and receive clock rates, in MHz
`define PSL_CLK_MHZ         125
`define PSL_RXCLK_MHZ       25
`define PSL_RXCLK_DIV       (`PSL_CLK_MHZ / `PSL_RXCLK_MHZ)
`define PSL_RXCLK_HIGH      (`PSL_RXCLK_DIV / 2)

`endif

// ==== design/psl_pkg.sv ====
/*
 * Types shared by the strap latch block: captured straps, receive
 * carrier, synchronised pin bundle and control states.
 * Assumes psl_consts.svh is available for numeric constants.
 */
package psl_pkg;

    // ============================================================
    // Captured power-on settings, bit 6 downward
    typedef struct packed {
        logic       mac_port_detach_strap;        // Bit 6
        logic       broadcast_addr_disable_strap; // Bit 5
        logic       interface_select_strap_msb;   // Bit 4
        logic       duplex_strap;                 // Bit 3
        logic [2:0] station_address_strap;        // Bits 2:0
    } psl_strap_t;

    // ============================================================
    // Receive nibble carrier from the core
    typedef struct packed {
        logic       rx_er;
        logic       rx_dv;
        logic [3:0] rxd;
    } psl_rx_t;

    // ============================================================
    // Bundle of pin levels passing the synchroniser
    typedef struct packed {
        logic       mdio;
        logic       mdc;
        logic       rx_er;
        logic       rx_clk;
        logic       rx_dv;
        logic [3:0] rxd;
    } psl_pins_t;

    // ============================================================
    // Control states
    typedef enum logic {
        st_capture,
        st_run
    } psl_state_t;

endpackage

// ==== design/psl_sync2.sv ====
/*
 * Two flip-flop level synchroniser of parameterised width.
 * Assumes inputs are asynchronous levels; no reset, data only.
 */
module psl_sync2 #(
    parameter int W = 1
) (
    input  wire logic         aclk,   // System clock
    input  wire logic [W-1:0] din,    // Asynchronous levels
    output      logic [W-1:0] dout    // Synchronised levels
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ============================================================
    // First stage is read only by the second
    always_ff @(posedge aclk) begin
        meta_ff <= din;
        sync_ff <= meta_ff;
    end

    assign dout = sync_ff;

endmodule // psl_sync2

// ==== verification/psl_top_chk.sv ====
/*
 * Port-level checker for the strap latch and shared receive pins.
 * Assumes board pulls hold the strap pins steady around reset release.
 */
module psl_top_chk (
    input wire logic                aclk,           // System clock
    input wire logic                aresetn,        // Sync reset, low
    input wire psl_pkg::psl_rx_t    rx_data,        // Core receive data
    input wire logic [3:0]          rxd_i,          // Nibble pin level
    input wire logic [3:0]          rxd_o,          // Nibble drive
    input wire logic                rxd_oe,         // Nibble enable
    input wire logic                rx_dv_i,        // Valid pin level
    input wire logic                rx_dv_o,        // Valid drive
    input wire logic                rx_clk_i,       // Clock pin level
    input wire logic                rx_clk_o,       // Clock drive
    input wire logic                rx_er_i,        // Error pin level
    input wire logic                rx_er_o,        // Error drive
    input wire logic                mdc_i,          // Management clock
    input wire logic                mdio_oe,        // MDIO pull enable
    input wire logic                mgmt_drive_en,  // Core owns MDIO
    input wire logic                mgmt_drive_bit, // Core MDIO bit
    input wire logic                mgmt_mdc_rise,  // MDC rise pulse
    input wire psl_pkg::psl_strap_t strap_cfg       // Captured straps
);
    timeunit 1ns;
    timeprecision 1ps;
    import psl_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ============================================================
    // Capture and hold; pins still undriven on the edge after release
    property p_off;
        $rose(aresetn) |-> !rxd_oe && !mdio_oe;
    endproperty
    a_off: assert property (p_off) else $error("driver on");
    property p_addr;
        $rose(aresetn) |=> strap_cfg[2:0] == {rxd_i[1], rxd_i[2], rxd_i[3]};
    endproperty
    a_addr: assert property (p_addr) else $error("address strap");
    property p_mode;
        $rose(aresetn) |=> strap_cfg[6:3] == {rx_er_i, rx_clk_i, rx_dv_i, rxd_i[0]};
    endproperty
    a_mode: assert property (p_mode) else $error("mode strap");
    // Two clean edges out of reset before straps must stay put
    property p_hold;
        $past(aresetn, 2) && $past(aresetn) |-> $stable(strap_cfg);
    endproperty
    a_hold: assert property (p_hold) else $error("strap moved");
    property p_oe_on;
        $rose(aresetn) |-> ##2 rxd_oe == !strap_cfg.mac_port_detach_strap;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("enable after");

    // ============================================================
    // Run mode pins
    property p_copy;
        $past(aresetn) |-> {rx_er_o, rx_dv_o, rxd_o} == $past(rx_data);
    endproperty
    a_copy: assert property (p_copy) else $error("rx copy");
    property p_rxclk;
        $rose(rx_clk_o) |-> rx_clk_o [*2] ##1 !rx_clk_o [*3] ##1 rx_clk_o;
    endproperty
    a_rxclk: assert property (p_rxclk) else $error("rx clock shape");

    // ============================================================
    // Management pins: only a 0 bit pulls, release once core lets go
    property p_mbit;
        mgmt_mdc_rise |-> mdio_oe == ($past(mgmt_drive_en) && !$past(mgmt_drive_bit));
    endproperty
    a_mbit: assert property (p_mbit) else $error("mdio pull");
    property p_mrel;
        !mgmt_drive_en |=> !mdio_oe;
    endproperty
    a_mrel: assert property (p_mrel) else $error("mdio held");
    property p_mdc;
        $rose(mdc_i) |-> ##[2:4] mgmt_mdc_rise;
    endproperty
    a_mdc: assert property (p_mdc) else $error("mdc rise missed");
endmodule // psl_top_chk

bind psl_top psl_top_chk psl_top_chk_i (.*);

// ==== verification/psl_mac_model.sv ====
/*
 * Management controller model: MDC frames and an open-drain MDIO puller.
 * Assumes the bench resolves the MDIO wire with a pull-up.
 */
module psl_mac_model (
    input  wire logic run,       // Frame open
    input  wire logic pull_low,  // Next bit is 0
    output      logic mdc,       // Management clock
    output      logic mdio_pull  // Pulling MDIO low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bit_ff = 1'b0;
    // Clock only inside a frame, parked low between frames
    initial mdc = 1'b0;
    always begin
        wait (run);
        #78 mdc = 1'b1;  // Edges fall between aclk edges
        #80 mdc = 1'b0;
        #2;
    end
    // Bit changes on the fall so the rise sees it settled
    always @(negedge mdc) bit_ff <= pull_low;
    assign mdio_pull = run & bit_ff; // Released outside frames
endmodule // psl_mac_model

// ==== verification/psl_top_tb.sv ====
/*
 * Self-checking bench for psl_top: straps, registers, rx pins, MDIO.
 * Assumes board pulls on shared pins and a pull-up on MDIO.
 */
`include "psl_consts.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module psl_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psl_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, rx_on = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, lfsr_ff = 32'hB07CD1EC;
    logic [3:0]  s_axi_wstrb = '0, rxd_i, rxd_o;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, rxd_oe, rx_dv_i, rx_dv_o, rx_dv_oe, rx_clk_i;
    logic        rx_clk_o, rx_clk_oe, rx_er_i, rx_er_o, rx_er_oe, mdc_i;
    logic        mdio_i, mdio_o, mdio_oe, mgmt_sample, mgmt_mdc_rise;
    logic        duplex_mode, detach_active, mac_pull;
    logic        mgmt_drive_en = 1'b0, mgmt_drive_bit = 1'b0;
    logic        mac_run = 1'b0, mac_low = 1'b0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [6:0]  pull = '0;
    psl_rx_t     rx_data = '0, rx_prev = '0;
    psl_strap_t  strap_cfg;
    int          err_total = 0, cmp_count = 0, cyc = 0;

    // Board level on every shared pin: driver when enabled, else pull
    assign rxd_i    = rxd_oe ? rxd_o : {pull[0], pull[1], pull[2], pull[3]};
    assign rx_dv_i  = rx_dv_oe ? rx_dv_o : pull[4];
    assign rx_clk_i = rx_clk_oe ? rx_clk_o : pull[5];
    assign rx_er_i  = rx_er_oe ? rx_er_o : pull[6];
    assign mdio_i   = !mac_pull && (mdio_oe ? mdio_o : 1'b1);

    psl_top psl_top_i (.*);
    psl_mac_model psl_mac_model_i (.run(mac_run), .pull_low(mac_low),
                                   .mdc(mdc_i), .mdio_pull(mac_pull));
    always #4 aclk = ~aclk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Receive model: each sample reappears one cycle later; hang guard
    always @(posedge aclk) begin
        if (rx_on) `CHK("rx_pins", rx_prev, {rx_er_o, rx_dv_o, rxd_o})
        rx_prev = rx_data;
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic do_reset(input logic [6:0] p);
        @(posedge aclk);
        aresetn <= 1'b0;
        pull    <= p;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    // Master holds each channel until its own ready is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Bounded wait for the detected MDC rise pulse
    task automatic wait_rise();
        int n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!mgmt_mdc_rise && n < 100);
    endtask

    // ============================================================
    // Main sequence: random straps, then all-high, then all-low
    initial begin
        for (int k = 0; k < 3; k++) begin
            lfsr_ff = lfsr_next(lfsr_ff);
            do_reset(k == 0 ? lfsr_ff[6:0] : (k == 1 ? 7'h7F : 7'h00));
            `CHK("strap_cfg", pull, strap_cfg)
            axi_rd(`PSL_STRAP_OFS, rd, rs);
            `CHK("strap_reg", {25'h0, pull}, rd)
            axi_rd(`PSL_CTRL_OFS, rd, rs);
            `CHK("ctrl", {30'h0, pull[3], pull[6]}, rd)
            `CHK("oe_init", !pull[6], rxd_oe)
            `CHK("duplex", pull[3], duplex_mode)
            axi_wr(`PSL_CTRL_OFS, 32'h1, 4'hF, rs);
            @(posedge aclk);
            `CHK("detach_oe", 3'b100, {detach_active, rxd_oe, rx_er_oe})
            axi_wr(`PSL_CTRL_OFS, 32'h2, 4'hF, rs);
            axi_wr(`PSL_CTRL_OFS, 32'h1, 4'h0, rs);
            @(posedge aclk);
            `CHK("run_oe", 4'hF, {rxd_oe, rx_dv_oe, rx_clk_oe, rx_er_oe})
            axi_rd(`PSL_STAT_OFS, rd, rs);
            `CHK("stat", 32'h3, rd)
            axi_wr(`PSL_STRAP_OFS, 32'hFFFFFFFF, 4'hF, rs);
            `CHK("ro_resp", `PSL_RESP_OKAY, rs)
            axi_wr(8'h0C, 32'h3, 4'hF, rs);
            `CHK("bad_wr", `PSL_RESP_SLVERR, rs)
            axi_rd(8'h0C, rd, rs);
            `CHK("bad_rd", {`PSL_RESP_SLVERR, 32'h0}, {rs, rd})
            // Random nibbles through the shared pins
            rx_on <= 1'b1;
            repeat (20) begin
                @(posedge aclk);
                lfsr_ff = lfsr_next(lfsr_ff);
                rx_data <= lfsr_ff[5:0];
            end
            @(posedge aclk);
            rx_on <= 1'b0;
            // Four bits from the controller, then four from the core
            mac_run <= 1'b1;
            for (int i = 0; i < 8; i++) begin
                lfsr_ff = lfsr_next(lfsr_ff);
                wait_rise();
                mac_low        <= (i < 4) && !lfsr_ff[0];
                mgmt_drive_en  <= (i >= 4);
                mgmt_drive_bit <= lfsr_ff[0];
                wait_rise();
                @(posedge aclk);
                if (i < 4) `CHK("mdio_in", lfsr_ff[0], mgmt_sample)
                else `CHK("mdio_out", lfsr_ff[0], mdio_i)
            end
            mac_run       <= 1'b0;
            mac_low       <= 1'b0;
            mgmt_drive_en <= 1'b0;
            axi_rd(`PSL_STRAP_OFS, rd, rs);
            `CHK("strap_keep", {25'h0, pull}, rd)
        end
        give_verdict();
    end
endmodule // psl_top_tb
